// >>> rtl/etprst_top.sv
// module: primary reset output driven by three programmable event trigger slots
module etprst_top #(
    parameter int unsigned HOLD_1S0_CYCLES = etprst_pkg::ETPRST_HOLD_1S0_CYC,
    parameter int unsigned HOLD_1S5_CYCLES = etprst_pkg::ETPRST_HOLD_1S5_CYC,
    parameter int unsigned HOLD_2S0_CYCLES = etprst_pkg::ETPRST_HOLD_2S0_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic event_valid,
    input wire logic [6:0] event_id,
    input wire logic event_is_key,
    input wire logic event_active,
    input wire logic ext_reset_n,
    output logic primary_reset_out
);
    import etprst_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [31:0] hold_target(input logic [2:0] code);
        case (code)
            ETPRST_TIME_NOW: hold_target = 32'h0;
            ETPRST_TIME_1S0: hold_target = HOLD_1S0_CYCLES;
            ETPRST_TIME_1S5: hold_target = HOLD_1S5_CYCLES;
            default: hold_target = HOLD_2S0_CYCLES;
        endcase
    endfunction : hold_target

    // does an event match a slot, and does it break the match
    function automatic logic [1:0] slot_hit(input logic [7:0] slot, input logic [6:0] id,
                                            input logic key, input logic act);
        logic same;
        same = (slot[ETPRST_ID_MSB:0] == id) && (id != 7'h00);
        // keys only ever match presses; a level-0 key slot never sets
        slot_hit[1] = same && (act == slot[ETPRST_LEVEL_BIT]) && !(key && !act);
        slot_hit[0] = same && (act != slot[ETPRST_LEVEL_BIT]);
    endfunction : slot_hit

    // ==========================================================
    // AHB-Lite slave
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] wr_idx_ff, nxt_wr_idx;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic [7:0] trig_ff [3];
    logic [7:0] nxt_trig [3];
    logic [7:0] cfg_ff, nxt_cfg;
    logic [2:0] match_ff, nxt_match;
    etprst_state_type state_ff, nxt_state;
    logic [31:0] cnt_ff, nxt_cnt;
    logic out_ff, nxt_out;
    logic addr_ok;
    logic [7:0] a_idx;
    logic [2:0] slot_on;
    logic all_match;

    assign addr_ok = hsel && htrans[1] && hready;
    assign a_idx = haddr[ETPRST_ADDR_SHIFT +: 8];

    // register writes land in the data phase; readback uses next values
    // so a read right behind a write sees the new contents
    always_comb
    begin
        nxt_wr_pend = addr_ok && hwrite && (haddr[31:10] == 22'h0);
        nxt_wr_idx = a_idx;
        for (int i = 0; i < 3; i++)
        begin
            nxt_trig[i] = trig_ff[i];
        end
        nxt_cfg = cfg_ff;
        if (wr_pend_ff)
        begin
            case (wr_idx_ff)
                ETPRST_IDX_TRIG_A: nxt_trig[0] = hwdata[7:0];
                ETPRST_IDX_TRIG_B: nxt_trig[1] = hwdata[7:0];
                ETPRST_IDX_TRIG_C: nxt_trig[2] = hwdata[7:0];
                ETPRST_IDX_CFG: nxt_cfg = {1'b0, hwdata[6:2], 2'b00};
                default: nxt_cfg = cfg_ff; // unmapped writes ignored
            endcase
        end
        nxt_hrdata = 32'h0;
        if (addr_ok && !hwrite && (haddr[31:10] == 22'h0))
        begin
            case (a_idx)
                ETPRST_IDX_TRIG_A: nxt_hrdata = {24'h0, nxt_trig[0]};
                ETPRST_IDX_TRIG_B: nxt_hrdata = {24'h0, nxt_trig[1]};
                ETPRST_IDX_TRIG_C: nxt_hrdata = {24'h0, nxt_trig[2]};
                ETPRST_IDX_CFG: nxt_hrdata = {24'h0, nxt_cfg};
                ETPRST_IDX_STATUS: nxt_hrdata = {27'h0, out_ff, state_ff == ETPRST_ST_FIRE,
                                                 match_ff[2], match_ff[1], match_ff[0]};
                default: nxt_hrdata = 32'h0;
            endcase
        end
    end

    // bus registers; zero wait states, always OKAY
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
            hrdata_ff <= 32'h0;
            cfg_ff <= ETPRST_CFG_RST;
            for (int i = 0; i < 3; i++)
            begin
                trig_ff[i] <= ETPRST_TRIG_RST;
            end
        end
        else
        begin
            wr_pend_ff <= nxt_wr_pend;
            wr_idx_ff <= nxt_wr_idx;
            hrdata_ff <= nxt_hrdata;
            cfg_ff <= nxt_cfg;
            trig_ff <= nxt_trig;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================================
    // slot match tracking
    // a rewritten slot starts unmatched, but an event in the same cycle that matches the old slot contents still sets it
    always_comb
    begin
        logic [1:0] hit;
        hit = 2'b00;
        nxt_match = match_ff;
        for (int i = 0; i < 3; i++)
        begin
            hit = slot_hit(trig_ff[i], event_id, event_is_key, event_active);
            if (wr_pend_ff && (wr_idx_ff == ETPRST_IDX_TRIG_A + 8'(i)))
            begin
                nxt_match[i] = 1'b0;
            end
            if (event_valid && hit[0])
            begin
                nxt_match[i] = 1'b0;
            end
            if (event_valid && hit[1])
            begin
                nxt_match[i] = 1'b1;
            end
            slot_on[i] = trig_ff[i][ETPRST_ID_MSB:0] != 7'h00;
        end
    end

    // disabled slots count as matched, but at least one slot must be on
    assign all_match = (slot_on != 3'b000) && ((match_ff | ~slot_on) == 3'b111);

    // ==========================================================
    // hold sequencer and output
    always_comb
    begin
        logic [31:0] target;
        logic req;
        target = hold_target(cfg_ff[ETPRST_CFG_TIME_MSB:ETPRST_CFG_TIME_LSB]);
        req = 1'b0;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ETPRST_ST_IDLE:
            begin
                nxt_cnt = 32'h0;
                if (all_match && (target == 32'h0))
                begin
                    nxt_state = ETPRST_ST_FIRE;
                end
                else if (all_match)
                begin
                    nxt_state = ETPRST_ST_HOLD;
                    nxt_cnt = 32'h1;
                end
            end
            ETPRST_ST_HOLD:
            begin
                // any broken match restarts the whole hold time
                if (!all_match)
                begin
                    nxt_state = ETPRST_ST_IDLE;
                    nxt_cnt = 32'h0;
                end
                else if (cnt_ff >= target)
                begin
                    nxt_state = ETPRST_ST_FIRE;
                end
                else
                begin
                    nxt_cnt = cnt_ff + 32'h1;
                end
            end
            ETPRST_ST_FIRE:
            begin
                if (!all_match)
                begin
                    nxt_state = ETPRST_ST_IDLE;
                end
                nxt_cnt = 32'h0;
            end
            default:
            begin
                nxt_state = ETPRST_ST_IDLE;
                nxt_cnt = 32'h0;
            end
        endcase
        req = (nxt_state == ETPRST_ST_FIRE) ||
              (cfg_ff[ETPRST_CFG_PASS_BIT] && !ext_reset_n);
        nxt_out = cfg_ff[ETPRST_CFG_POL_BIT] ? req : !req;
    end

    // sequencer registers; output idles high (active low by default)
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            match_ff <= 3'b000;
            state_ff <= ETPRST_ST_IDLE;
            cnt_ff <= 32'h0;
            out_ff <= 1'b1;
        end
        else
        begin
            match_ff <= nxt_match;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
        end
    end

    assign primary_reset_out = out_ff;

    // ==========================================================
    // checks
    default clocking ast_clk @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic [1:0] ast_hit_b;
    assign ast_hit_b = slot_hit(trig_ff[1], event_id, event_is_key, event_active);

    sequence key_release_a;
        event_valid && event_is_key && !event_active && trig_ff[0][6:0] == event_id;
    endsequence

    sequence input_match_a;
        event_valid && !event_is_key && trig_ff[0][6:0] == event_id && event_id != 7'h00
            && event_active == trig_ff[0][7];
    endsequence

    sequence slot_a_write;
        wr_pend_ff && wr_idx_ff == ETPRST_IDX_TRIG_A;
    endsequence

    AST_KEY_RELEASE_NEVER: assert property (key_release_a ##0 !match_ff[0] |=> !match_ff[0])
        else $error("key release set a slot match");
    AST_INPUT_LEVEL_MATCH: assert property (input_match_a |=> match_ff[0])
        else $error("input event of selected level did not match slot a");
    AST_SLOT_READBACK: assert property (slot_a_write |=> trig_ff[0] == $past(hwdata[7:0]))
        else $error("slot a did not store written byte");
    AST_SLOT_INDEPENDENT: assert property (!event_valid && !wr_pend_ff |=> $stable(match_ff))
        else $error("slot match changed without cause");
    AST_ZERO_SLOT_IGNORED: assert property (trig_ff[0][6:0] == 7'h00
        && !(wr_pend_ff && wr_idx_ff == ETPRST_IDX_TRIG_A)
        |=> !match_ff[0] || $past(match_ff[0]))
        else $error("zero-id slot a gained a match");
    AST_FIRE_NEEDS_ALL: assert property (!all_match |=> state_ff != ETPRST_ST_FIRE)
        else $error("reset fired with an unmatched enabled slot");
    AST_SLOT_B_SAME_CODE: assert property (event_valid && ast_hit_b[1] && !ast_hit_b[0]
        |=> match_ff[1])
        else $error("slot b level decoding differs from slot a");
    AST_IMMEDIATE_FIRE: assert property (state_ff == ETPRST_ST_IDLE && all_match
        && cfg_ff[4:2] == ETPRST_TIME_NOW |=> state_ff == ETPRST_ST_FIRE)
        else $error("immediate hold code did not fire next cycle");
    AST_NO_EARLY_FIRE: assert property (state_ff == ETPRST_ST_IDLE && all_match
        && cfg_ff[4:2] == ETPRST_TIME_1S0 |=> (state_ff != ETPRST_ST_FIRE) [*2])
        else $error("timed hold fired too early");
    AST_POLARITY: assert property ($past(cfg_ff[6]) == 1'b0 && state_ff == ETPRST_ST_FIRE
        |-> !primary_reset_out)
        else $error("active-low output not low while firing");
    AST_PASSTHROUGH: assert property (cfg_ff[5] && !ext_reset_n && $stable(cfg_ff)
        |=> primary_reset_out == $past(cfg_ff[6]))
        else $error("external reset not passed to output");
    AST_ALL_ZERO_QUIET: assert property (slot_on == 3'b000 |=> state_ff == ETPRST_ST_IDLE)
        else $error("output asserted with all slots disabled");

endmodule : etprst_top

// >>> rtl/etprst_pkg.sv
// package: constants and types of the event-triggered primary reset block
package etprst_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] ETPRST_IDX_TRIG_A = 8'h29;
    localparam logic [7:0] ETPRST_IDX_TRIG_B = 8'h2A;
    localparam logic [7:0] ETPRST_IDX_TRIG_C = 8'h2B;
    localparam logic [7:0] ETPRST_IDX_CFG = 8'h2E;
    localparam logic [7:0] ETPRST_IDX_STATUS = 8'h2F;
    localparam int ETPRST_ADDR_SHIFT = 2;

    // ==========================================================
    // field positions
    localparam int ETPRST_LEVEL_BIT = 7;
    localparam int ETPRST_ID_MSB = 6;
    localparam int ETPRST_CFG_POL_BIT = 6;
    localparam int ETPRST_CFG_PASS_BIT = 5;
    localparam int ETPRST_CFG_TIME_MSB = 4;
    localparam int ETPRST_CFG_TIME_LSB = 2;

    // ==========================================================
    // values after reset
    localparam logic [7:0] ETPRST_TRIG_RST = 8'h00;
    localparam logic [7:0] ETPRST_CFG_RST = 8'h00;

    // ==========================================================
    // hold-time codes
    localparam logic [2:0] ETPRST_TIME_NOW = 3'h0;
    localparam logic [2:0] ETPRST_TIME_1S0 = 3'h1;
    localparam logic [2:0] ETPRST_TIME_1S5 = 3'h2;
    localparam logic [2:0] ETPRST_TIME_2S0 = 3'h3;

    // ==========================================================
    // timing: clock rate and hold times in their own units
    localparam int unsigned ETPRST_CLK_KHZ = 200000;
    localparam int unsigned ETPRST_HOLD_1S0_MS = 1000;
    localparam int unsigned ETPRST_HOLD_1S5_MS = 1500;
    localparam int unsigned ETPRST_HOLD_2S0_MS = 2000;
    localparam int unsigned ETPRST_HOLD_1S0_CYC = ETPRST_HOLD_1S0_MS * ETPRST_CLK_KHZ;
    localparam int unsigned ETPRST_HOLD_1S5_CYC = ETPRST_HOLD_1S5_MS * ETPRST_CLK_KHZ;
    localparam int unsigned ETPRST_HOLD_2S0_CYC = ETPRST_HOLD_2S0_MS * ETPRST_CLK_KHZ;

    // ==========================================================
    // trigger sequencer states
    typedef enum logic [1:0] {
        ETPRST_ST_IDLE = 2'b00,
        ETPRST_ST_HOLD = 2'b01,
        ETPRST_ST_FIRE = 2'b10
    } etprst_state_type;

endpackage : etprst_pkg

// >>> bench/etprst_event_src.sv
// partner model: event decoder and external reset source feeding the trigger block
module etprst_event_src (
    input wire logic ref_clk,
    output logic event_valid,
    output logic [6:0] event_id,
    output logic event_is_key,
    output logic event_active,
    output logic ext_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // idle levels at time zero
    initial
    begin
        event_valid = 1'b0;
        event_id = 7'h00;
        event_is_key = 1'b0;
        event_active = 1'b0;
        ext_reset_n = 1'b1;
    end

    // one-cycle event pulse; qualifiers scrambled after release so stale values never match
    task automatic send(input logic [6:0] id, input logic key, input logic act);
        @(posedge ref_clk);
        event_valid <= 1'b1;
        event_id <= id;
        event_is_key <= key;
        event_active <= act;
        @(posedge ref_clk);
        event_valid <= 1'b0;
        event_id <= ~id;
        event_is_key <= ~key;
        event_active <= ~act;
    endtask : send

    // external reset level, changed just after an edge
    task automatic ext(input logic lvl);
        @(posedge ref_clk);
        ext_reset_n <= lvl;
    endtask : ext
endmodule : etprst_event_src

// >>> bench/etprst_bench.sv
// testbench: register access, slot matching, hold times, polarity and pass-through
module etprst_bench import etprst_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, event_valid, event_is_key, event_active, ext_reset_n, out;
    logic [6:0] event_id;
    int miscompares = 0;
    int num_checks = 0;

    // ==========================================================
    // clock and instances; short hold counts keep the run brief
    always #2.5 ref_clk = ~ref_clk;
    etprst_top #(.HOLD_1S0_CYCLES(10), .HOLD_1S5_CYCLES(15), .HOLD_2S0_CYCLES(20)) i_etprst_top (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .event_valid(event_valid), .event_id(event_id),
        .event_is_key(event_is_key), .event_active(event_active), .ext_reset_n(ext_reset_n),
        .primary_reset_out(out));
    etprst_event_src i_evt (.ref_clk(ref_clk), .event_valid(event_valid), .event_id(event_id),
        .event_is_key(event_is_key), .event_active(event_active), .ext_reset_n(ext_reset_n));

    // ==========================================================
    // helpers
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // single word transfer; waits on hready in both phases
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        xfer(idx, 1'b1, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        xfer(idx, 1'b0, 32'h0, q);
        check("register", exp, q);
    endtask : rd_chk

    task automatic out_chk(input string name, input logic lvl);
        check(name, {31'h0, lvl}, {31'h0, out});
    endtask : out_chk

    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [7:0] idx[4] = '{ETPRST_IDX_TRIG_A, ETPRST_IDX_TRIG_B,
                               ETPRST_IDX_TRIG_C, ETPRST_IDX_CFG};
        out_chk("idle out", 1'b1);
        foreach (idx[i]) rd_chk(idx[i], {24'h0, (i == 3) ? ETPRST_CFG_RST : ETPRST_TRIG_RST});
        i_evt.send(7'h05, 1'b1, 1'b1);
        tick(3);
        out_chk("all slots zero", 1'b1);
        wr(ETPRST_IDX_TRIG_A, 32'hFFFF_FF85);
        wr(ETPRST_IDX_TRIG_B, 32'h0000_007F);
        wr(ETPRST_IDX_TRIG_C, 32'h0000_0080);
        rd_chk(ETPRST_IDX_TRIG_A, 32'h85);
        rd_chk(ETPRST_IDX_TRIG_B, 32'h7F);
        rd_chk(ETPRST_IDX_TRIG_C, 32'h80);
        wr(ETPRST_IDX_CFG, 32'hFF);
        rd_chk(ETPRST_IDX_CFG, 32'h7C);
        wr(8'h40, 32'hFF);
        rd_chk(8'h40, 32'h0);
        foreach (idx[i]) wr(idx[i], 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_single();
        wr(ETPRST_IDX_TRIG_A, 32'h91);
        i_evt.send(7'h11, 1'b1, 1'b0);
        tick(3);
        out_chk("key release", 1'b1);
        i_evt.send(7'h11, 1'b1, 1'b1);
        tick(2);
        out_chk("key press", 1'b0);
        rd_chk(ETPRST_IDX_STATUS, 32'h09);
        i_evt.send(7'h11, 1'b1, 1'b0);
        tick(3);
        out_chk("after release", 1'b1);
        $display("test single done");
    endtask : t_single

    task automatic t_all();
        wr(ETPRST_IDX_TRIG_B, 32'h22);
        wr(ETPRST_IDX_TRIG_C, 32'hB3);
        i_evt.send(7'h11, 1'b1, 1'b1);
        i_evt.send(7'h22, 1'b0, 1'b0);
        tick(3);
        out_chk("two of three", 1'b1);
        rd_chk(ETPRST_IDX_STATUS, 32'h13);
        i_evt.send(7'h33, 1'b0, 1'b1);
        tick(2);
        out_chk("three matched", 1'b0);
        i_evt.send(7'h22, 1'b0, 1'b1);
        tick(3);
        out_chk("level0 slot broken", 1'b1);
        wr(ETPRST_IDX_TRIG_B, 32'h0);
        wr(ETPRST_IDX_TRIG_C, 32'h0);
        i_evt.send(7'h11, 1'b1, 1'b0);
        $display("test all done");
    endtask : t_all

    task automatic t_hold();
        logic [2:0] code[4] = '{ETPRST_TIME_NOW, ETPRST_TIME_1S0,
                                ETPRST_TIME_1S5, ETPRST_TIME_2S0};
        // edges from the match to the output: the hold count plus the edge into holding
        int lim[4] = '{1, 11, 16, 21};
        int n;
        foreach (code[i])
        begin
            wr(ETPRST_IDX_CFG, {27'h0, code[i], 2'h0});
            i_evt.send(7'h11, 1'b1, 1'b1);
            n = 0;
            while (out !== 1'b0 && n < 40)
            begin
                tick(1);
                n++;
            end
            check("hold cycles", 32'(lim[i]), 32'(n));
            i_evt.send(7'h11, 1'b1, 1'b0);
            tick(3);
        end
        $display("test hold done");
    endtask : t_hold

    task automatic t_pol_pass();
        wr(ETPRST_IDX_CFG, 32'h40);
        tick(1);
        out_chk("high idle", 1'b0);
        i_evt.send(7'h11, 1'b1, 1'b1);
        tick(2);
        out_chk("high active", 1'b1);
        i_evt.send(7'h11, 1'b1, 1'b0);
        wr(ETPRST_IDX_CFG, 32'h20);
        tick(1);
        out_chk("low idle", 1'b1);
        i_evt.ext(1'b0);
        tick(2);
        out_chk("pass on", 1'b0);
        wr(ETPRST_IDX_CFG, 32'h0);
        tick(2);
        out_chk("pass off", 1'b1);
        i_evt.ext(1'b1);
        $display("test polarity done");
    endtask : t_pol_pass

    // ==========================================================
    // verdict, sequence and watchdog
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // main sequence after four cycles of reset
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(1);
        t_regs();
        t_single();
        t_all();
        t_hold();
        t_pol_pass();
        end_of_test();
    end

    // hang guard, well above the few hundred cycles the tests need
    initial
    begin
        #100000;
        miscompares++;
        end_of_test();
    end
endmodule : etprst_bench
